// file: muf_flow_ctrl.v
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "muf_defs.vh"


module muf_flow_ctrl #(
  parameter FIFO_DEPTH = `MUF_FIFO_DEPTH
) (
  input wire clk,
  input wire rst_b,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // link pins
  input wire clearToSendInput,
  output reg requestToSendOutput,
  // rest of the uart
  input wire [3:0] rxFifoLevel,
  input wire txStartReq,
  input wire txSymbolDone,
  input wire rxStartDetect,
  input wire rxSymbolDone,
  output reg txStartGo,
  output reg rxStartGo
);

  // ************************************************************
  // helpers
  // ************************************************************
  function [2:0] freeThreshold;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: freeThreshold = `MUF_LVL_00;
        2'b01: freeThreshold = `MUF_LVL_01;
        2'b10: freeThreshold = `MUF_LVL_10;
        default: freeThreshold = `MUF_LVL_11;
      endcase
    end
  endfunction

  function [7:0] flowStatus;
    input [3:0] level;
    input ctsPin;
    input rtsPin;
    input txBusy;
    input rxBusy;
    begin
      flowStatus = 8'h00;
      flowStatus[`MUF_FST_LVL_HI:`MUF_FST_LVL_LO] = level;
      flowStatus[`MUF_FST_CTS_PIN] = ctsPin;
      flowStatus[`MUF_FST_RTS_PIN] = rtsPin;
      flowStatus[`MUF_FST_TX_BUSY] = txBusy;
      flowStatus[`MUF_FST_RX_BUSY] = rxBusy;
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  localparam [4:0] DEPTH5 = FIFO_DEPTH;

  // ************************************************************
  // state
  // ************************************************************
  reg [7:0] extraControl;
  reg [7:0] tempByte;
  reg manualRts;
  reg txState;
  reg rxState;
  reg [`MUF_ADDR_BITS-1:0] busAddr;
  reg busWrite;
  reg busRead;
  reg [7:0] next_extraControl;
  reg [7:0] next_tempByte;
  reg next_manualRts;
  reg next_txState;
  reg next_txStartGo;
  reg next_rxState;
  reg next_rxStartGo;
  wire txAllowed;
  wire rxAllowed;
  wire ctsSync;
  wire ctsAsserted;
  wire [4:0] freeSpace;
  wire [2:0] threshold;
  wire autoRtsAsserted;
  wire next_rtsPin;
  wire addrPhase;
  reg [31:0] readValue;

  muf_sync ctsSyncInst (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(clearToSendInput),
    .pinSync(ctsSync)
  );

  // ************************************************************
  // flow control decode
  // ************************************************************
  // polarity applies to the auto flow view only
  assign ctsAsserted = extraControl[`MUF_CTL_CTS_POL] ? ~ctsSync : ctsSync;
  assign freeSpace = DEPTH5 - {1'b0, rxFifoLevel};
  assign threshold = freeThreshold(
    extraControl[`MUF_CTL_LVL_HI:`MUF_CTL_LVL_LO]);
  // no hysteresis: re-asserts as soon as free space passes threshold
  assign autoRtsAsserted = freeSpace > {2'b00, threshold};
  assign next_rtsPin = extraControl[`MUF_CTL_RTS_FLOW] ?
    (autoRtsAsserted ^ extraControl[`MUF_CTL_RTS_POL]) :
    ~manualRts;

  // ************************************************************
  // request-to-send pin
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      requestToSendOutput <= 1'b1;
    end else begin
      requestToSendOutput <= next_rtsPin;
    end
  end

  // ************************************************************
  // transmit start gating
  // ************************************************************
  // gating only at symbol start, so a running symbol always completes
  assign txAllowed = extraControl[`MUF_CTL_TX_EN] &&
    (!extraControl[`MUF_CTL_CTS_FLOW] || ctsAsserted);

  always @* begin
    next_txState = txState;
    next_txStartGo = 1'b0;
    case (txState)
      ST_IDLE: begin
        if (txStartReq && txAllowed) begin
          next_txStartGo = 1'b1;
          next_txState = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (txSymbolDone) begin
          next_txState = ST_IDLE;
        end
      end
      default: next_txState = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      txState <= ST_IDLE;
      txStartGo <= 1'b0;
    end else begin
      txState <= next_txState;
      txStartGo <= next_txStartGo;
    end
  end

  // ************************************************************
  // receive start gating
  // ************************************************************
  // a symbol already under way is never cut short by a disable
  assign rxAllowed = extraControl[`MUF_CTL_RX_EN];

  always @* begin
    next_rxState = rxState;
    next_rxStartGo = 1'b0;
    case (rxState)
      ST_IDLE: begin
        if (rxStartDetect && rxAllowed) begin
          next_rxStartGo = 1'b1;
          next_rxState = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (rxSymbolDone) begin
          next_rxState = ST_IDLE;
        end
      end
      default: next_rxState = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      rxState <= ST_IDLE;
      rxStartGo <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxStartGo <= next_rxStartGo;
    end
  end

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  assign addrPhase = hsel && htrans[`MUF_HTRANS_NONSEQ_BIT] && hready;

  // ************************************************************
  // register readback
  // ************************************************************
  always @* begin
    readValue = 32'h0000_0000;
    case (busAddr)
      `MUF_OFS_MODEM_CTRL: readValue[`MUF_MCR_RTS] = manualRts;
      `MUF_OFS_MODEM_STAT: readValue[`MUF_MSR_CTS] = ~ctsSync;
      `MUF_OFS_TEMP_BYTE: readValue[7:0] = tempByte;
      `MUF_OFS_EXTRA_CTRL: readValue[7:0] = extraControl;
      `MUF_OFS_FLOW_STAT: readValue[7:0] = flowStatus(rxFifoLevel, ctsSync,
        requestToSendOutput, txState, rxState);
      default: readValue = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // bus data phase
  // ************************************************************
  // reads take one wait state so a write just before is seen
  always @(posedge clk) begin
    if (!rst_b) begin
      busAddr <= {`MUF_ADDR_BITS{1'b0}};
      busWrite <= 1'b0;
      busRead <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (busRead) begin
        hrdata <= readValue;
        hreadyout <= 1'b1;
        busRead <= 1'b0;
      end else if (addrPhase) begin
        busAddr <= haddr[`MUF_ADDR_BITS-1:0];
        busWrite <= hwrite;
        busRead <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        busWrite <= 1'b0;
      end
      if (busWrite && !addrPhase) begin
        busWrite <= 1'b0;
      end
    end
  end

  // ************************************************************
  // register write decode
  // ************************************************************
  // writes to read-only offsets fall through and change nothing
  always @* begin
    next_extraControl = extraControl;
    next_tempByte = tempByte;
    next_manualRts = manualRts;
    if (busWrite) begin
      case (busAddr)
        `MUF_OFS_MODEM_CTRL: next_manualRts = hwdata[`MUF_MCR_RTS];
        `MUF_OFS_TEMP_BYTE: next_tempByte = hwdata[7:0];
        `MUF_OFS_EXTRA_CTRL: next_extraControl = hwdata[7:0];
        default: next_tempByte = tempByte;
      endcase
    end
  end

  // ************************************************************
  // register load
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      extraControl <= `MUF_CTL_RESET;
      tempByte <= `MUF_TEMP_RESET;
      manualRts <= `MUF_MCR_RESET;
    end else begin
      extraControl <= next_extraControl;
      tempByte <= next_tempByte;
      manualRts <= next_manualRts;
    end
  end

endmodule // muf_flow_ctrl

// file: muf_defs.vh
`ifndef MUF_DEFS_VH
`define MUF_DEFS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define MUF_OFS_MODEM_CTRL 8'h00
`define MUF_OFS_MODEM_STAT 8'h04
`define MUF_OFS_TEMP_BYTE 8'h08
`define MUF_OFS_EXTRA_CTRL 8'h0C
`define MUF_OFS_FLOW_STAT 8'h10

// ************************************************************
// field positions
// ************************************************************
`define MUF_MCR_RTS 1
`define MUF_MSR_CTS 4
`define MUF_CTL_CTS_POL 7
`define MUF_CTL_RTS_POL 6
`define MUF_CTL_LVL_HI 5
`define MUF_CTL_LVL_LO 4
`define MUF_CTL_CTS_FLOW 3
`define MUF_CTL_RTS_FLOW 2
`define MUF_CTL_TX_EN 1
`define MUF_CTL_RX_EN 0
`define MUF_FST_LVL_HI 3
`define MUF_FST_LVL_LO 0
`define MUF_FST_CTS_PIN 4
`define MUF_FST_RTS_PIN 5
`define MUF_FST_TX_BUSY 6
`define MUF_FST_RX_BUSY 7

// ************************************************************
// reset values and constants
// ************************************************************
`define MUF_CTL_RESET 8'h03
`define MUF_TEMP_RESET 8'h00
`define MUF_MCR_RESET 1'b0
`define MUF_FIFO_DEPTH 8
`define MUF_LVL_00 3'h3
`define MUF_LVL_01 3'h2
`define MUF_LVL_10 3'h1
`define MUF_LVL_11 3'h4
`define MUF_HTRANS_NONSEQ_BIT 1
`define MUF_ADDR_BITS 8

`endif

// file: muf_sync.v
`timescale 1ns/10ps

// ************************************************************
// two-flop synchroniser for one pin level
// ************************************************************
module muf_sync (
  input wire clk,
  input wire rst_b,
  input wire pinIn,
  output reg pinSync
);
  reg stage1;

  // first stage feeds only the second one
  always @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      stage1 <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule // muf_sync

// file: muf_flow_ctrl_chk.sv
`timescale 1ns/10ps
// ********
// bus, start-pulse and rts reset checks
// ********
module muf_flow_ctrl_chk (
  input wire clk,
  input wire rst_b,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire txStartReq,
  input wire txStartGo,
  input wire rxStartGo,
  input wire requestToSendOutput
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_okay_resp: assert property (!hresp) else $error("hresp not okay");
  a_write_nowait: assert property (s_wr_take |=> hreadyout) else $error("write stalled");
  a_read_wait: assert property (s_rd_take |=> s_one_wait) else $error("read wait wrong");
  a_wait_short: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  a_tx_pulse: assert property (txStartGo |=> !txStartGo) else $error("tx go not a pulse");
  a_rx_pulse: assert property (rxStartGo |=> !rxStartGo) else $error("rx go not a pulse");
  a_tx_cause: assert property (txStartGo |-> $past(txStartReq)) else $error("tx go uncaused");
  a_rts_reset: assert property ($rose(rst_b) |-> requestToSendOutput) else $error("rts low");
endmodule // muf_flow_ctrl_chk

bind muf_flow_ctrl muf_flow_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .txStartReq(txStartReq), .txStartGo(txStartGo), .rxStartGo(rxStartGo),
  .requestToSendOutput(requestToSendOutput));

// file: muf_peer.sv
`timescale 1ns/10ps
// ********
// remote serial peer
// ********
module muf_peer (
  input wire clk,
  input wire rtsLine,
  input wire rtsLowAct,
  input wire sendReq,
  input wire ctsCmd,
  output logic ctsLine = 1'b0,
  output logic startSeen = 1'b0
);
  // peer holds off its start bit while our ready line is de-asserted
  always @(posedge clk) begin
    startSeen <= sendReq && (rtsLine != rtsLowAct);
    ctsLine <= ctsCmd;
  end
endmodule // muf_peer

// file: muf_flow_ctrl_test.sv
`timescale 1ns/10ps
module muf_flow_ctrl_test;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, txStartReq = 0, txSymbolDone = 0;
  logic rxSymbolDone = 0, sendReq = 0, ctsCmd = 0, rtsPol = 0;
  logic [1:0] htrans = 0;
  logic [3:0] rxFifoLevel = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, cts, rts, startSeen, txStartGo, rxStartGo;
  int err_count = 0, checks = 0, exp, n, i, j;
  muf_flow_ctrl uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clearToSendInput(cts), .requestToSendOutput(rts),
    .rxFifoLevel(rxFifoLevel), .txStartReq(txStartReq), .txSymbolDone(txSymbolDone),
    .rxStartDetect(startSeen), .rxSymbolDone(rxSymbolDone), .txStartGo(txStartGo),
    .rxStartGo(rxStartGo));
  muf_peer peer (.clk(clk), .rtsLine(rts), .rtsLowAct(rtsPol), .sendReq(sendReq),
    .ctsCmd(ctsCmd), .ctsLine(cts), .startSeen(startSeen));
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
  task wrap_up();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ********
  // bus master and symbol helpers
  // ********
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task count_go(input logic tx);
    n = 0;
    repeat (4) begin
      @(posedge clk);
      n += tx ? txStartGo : rxStartGo;
    end
  endtask
  task finish_sym();
    txSymbolDone <= 1;
    rxSymbolDone <= 1;
    @(posedge clk);
    txSymbolDone <= 0;
    rxSymbolDone <= 0;
  endtask
  initial begin
    n = $urandom(61914);
    repeat (3) @(posedge clk);
    rst_b <= 1;
    bus(0, 8'h0C, 0);
    chk("ctl", 32'h03, rd);
    bus(0, 8'h08, 0);
    chk("temp", 32'h00, rd);
    bus(1, 8'h04, 32'hFF);
    bus(0, 8'h04, 0);
    chk("msr", 32'h10, rd);
    bus(0, 8'h20, 0);
    chk("unmapped", 32'h00, rd);
    for (i = 0; i < 4; i++) begin
      n = $urandom;
      bus(1, 8'h08, n);
      bus(0, 8'h08, 0);
      chk("temp", n & 8'hFF, rd);
    end
    ctsCmd <= 1;
    repeat (4) @(posedge clk);
    bus(0, 8'h04, 0);
    chk("msr", 32'h00, rd);
    bus(1, 8'h00, 32'h02);
    repeat (2) @(posedge clk);
    chk("rts", 0, rts);
    bus(1, 8'h00, 32'h00);
    repeat (2) @(posedge clk);
    chk("rts", 1, rts);
    for (i = 0; i < 8; i++) begin
      // every threshold code tried, not only the usual one
      bus(1, 8'h0C, 8'h07 | (i % 4) << 4 | i[2] << 6);
      for (j = 0; j <= 8; j++) begin
        rxFifoLevel <= j[3:0];
        repeat (3) @(posedge clk);
        exp = ((8 - j) > ((i % 4 == 3) ? 4 : 3 - i % 4)) ^ i[2];
        chk("rts", exp, rts);
      end
    end
    for (i = 0; i < 16; i++) begin
      ctsCmd <= 1;
      bus(1, 8'h0C, 32'h03);
      txStartReq <= 1;
      count_go(1);
      txStartReq <= 0;
      chk("txgo", 1, n);
      ctsCmd <= i[2];
      bus(1, 8'h0C, {i[1], 3'h0, i[0], 1'h1, i[3], 1'h1});
      repeat (3) @(posedge clk);
      bus(0, 8'h10, 0);
      chk("txbusy", 1, rd[6]);
      finish_sym();
      txStartReq <= 1;
      count_go(1);
      txStartReq <= 0;
      exp = i[3] && (!i[0] || (i[1] ? !i[2] : i[2]));
      chk("txgo", exp, n);
      finish_sym();
    end
    rxFifoLevel <= 0;
    rtsPol <= 0;
    bus(1, 8'h0C, 32'h05);
    sendReq <= 1;
    count_go(0);
    sendReq <= 0;
    chk("rxgo", 1, n);
    bus(1, 8'h0C, 32'h04);
    bus(0, 8'h10, 0);
    chk("rxbusy", 1, rd[7]);
    finish_sym();
    sendReq <= 1;
    count_go(0);
    sendReq <= 0;
    chk("rxgo", 0, n);
    wrap_up();
  end
endmodule // muf_flow_ctrl_test
